// [core/uart_baud_clock_frame.sv]
// module: baud generator, transfer clock logic and frame engine with AXI4-Lite registers
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module uart_baud_clock_frame (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [4:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic        xck_in,
  output logic             xck_out,
  output logic             xck_oe_n
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  uart_frame_pkg::fmt_t      fmt_q, fmt_d;
  uart_frame_pkg::tx_state_t tx_st_q, tx_st_d;
  uart_frame_pkg::rx_state_t rx_st_q, rx_st_d;
  logic        aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [4:0]  awaddr_q, awaddr_d;
  logic [7:0]  wbyte_q, wbyte_d;
  logic        wlane_q, wlane_d;
  logic        awready_q, awready_d, wready_q, wready_d;
  logic        bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        txen_q, txen_d, rxen_q, rxen_d, tx9_q, tx9_d;
  logic        txc_q, txc_d, rxc_q, rxc_d;
  logic [11:0] div_q, div_d;
  logic        wr_go, reload, tx_start, tx_done, rx_done, tick;
  logic [7:0]  rbyte;
  logic        rxd_s1_q, rxd_s2_q, xck_s1_q, xck_s2_q, xck_s3_q, xck_q;
  logic        xck_d, xck_oe_n_d;
  logic [3:0]  tx_ph_q, tx_ph_d;
  logic        master, rise, fall, chg_edge, smp_edge, tx_bit_en;
  logic [3:0]  ovs_last, mid, n_bits;
  logic        par_en, par_odd;
  logic [8:0]  tx_word, mask;
  logic [12:0] frame, frame_q, frame_d;
  logic [3:0]  total, tx_cnt_q, tx_cnt_d;
  logic        txd_q, txd_d;
  logic [3:0]  rx_ph_q, rx_ph_d, rx_idx_q, rx_idx_d;
  logic [8:0]  rx_sh_q, rx_sh_d, rx_data_q, rx_data_d;
  logic        rx_par_q, rx_par_d, fe_q, fe_d, pe_q, pe_d, samp;

  // ----------------------------------------------------------------
  // shared frame format decode
  // ----------------------------------------------------------------
  always_comb begin
    case (fmt_q.char_size)
      3'h0:    n_bits = 4'h5;
      3'h1:    n_bits = 4'h6;
      3'h2:    n_bits = 4'h7;
      3'h7:    n_bits = 4'h9;
      default: n_bits = 4'h8;
    endcase
    par_en  = fmt_q.parity_mode[1];
    par_odd = fmt_q.parity_mode[0];
    for (int i = 0; i < 9; i++) begin
      mask[i] = (4'(i) < n_bits);
    end
  end

  // ----------------------------------------------------------------
  // register bus and control registers
  // ----------------------------------------------------------------
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d  = w_held_q;
    awaddr_d  = awaddr_q;
    wbyte_d   = wbyte_q;
    wlane_d   = wlane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    fmt_d     = fmt_q;
    txen_d    = txen_q;
    rxen_d    = rxen_q;
    tx9_d     = tx9_q;
    div_d     = div_q;
    txc_d     = txc_q;
    rxc_d     = rxc_q;
    reload    = 1'b0;
    tx_start  = 1'b0;
    if (awvalid && awready_q) begin
      aw_held_d = 1'b1;
      awaddr_d  = awaddr;
    end
    if (wvalid && wready_q) begin
      w_held_d = 1'b1;
      wbyte_d  = wdata[7:0];
      wlane_d  = wstrb[0];
    end
    wr_go = aw_held_q && w_held_q && !bvalid_q;
    if (wr_go) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = uart_frame_pkg::RESP_OKAY;
      case (awaddr_q)
        uart_frame_pkg::OFF_DATA: begin
          tx_start = wlane_q && txen_q && (tx_st_q == uart_frame_pkg::TX_IDLE);
        end
        uart_frame_pkg::OFF_CTRL_A: begin
          if (wlane_q) begin
            fmt_d.double_rate = wbyte_q[uart_frame_pkg::A_DBL];
            if (wbyte_q[uart_frame_pkg::A_TXC]) begin
              txc_d = 1'b0;
            end
          end
        end
        uart_frame_pkg::OFF_CTRL_B: begin
          if (wlane_q) begin
            fmt_d.master       = wbyte_q[uart_frame_pkg::B_DIR];
            rxen_d             = wbyte_q[uart_frame_pkg::B_RXEN];
            txen_d             = wbyte_q[uart_frame_pkg::B_TXEN];
            fmt_d.char_size[2] = wbyte_q[uart_frame_pkg::B_CSZ2];
            tx9_d              = wbyte_q[uart_frame_pkg::B_TX9];
          end
        end
        uart_frame_pkg::OFF_BAUD_LOW: begin
          if (wlane_q) begin
            div_d[7:0] = wbyte_q;
            reload     = 1'b1;
          end
        end
        uart_frame_pkg::OFF_SHARED: begin
          if (wlane_q && wbyte_q[uart_frame_pkg::C_SEL]) begin
            fmt_d.sync          = wbyte_q[uart_frame_pkg::C_SYNC];
            fmt_d.parity_mode   = wbyte_q[uart_frame_pkg::C_PAR +: 2];
            fmt_d.stop2         = wbyte_q[uart_frame_pkg::C_STOP];
            fmt_d.char_size[1:0] = wbyte_q[uart_frame_pkg::C_CSZ +: 2];
            fmt_d.polarity      = wbyte_q[uart_frame_pkg::C_POL];
          end else if (wlane_q) begin
            div_d[11:8] = wbyte_q[3:0];
          end
        end
        default: bresp_d = uart_frame_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    rbyte = 8'h00;
    if (arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = uart_frame_pkg::RESP_OKAY;
      case (araddr)
        uart_frame_pkg::OFF_DATA: begin
          rbyte = rx_data_q[7:0];
          rxc_d = 1'b0;
        end
        uart_frame_pkg::OFF_CTRL_A: begin
          rbyte[uart_frame_pkg::A_RXC] = rxc_q;
          rbyte[uart_frame_pkg::A_TXC] = txc_q;
          rbyte[uart_frame_pkg::A_FE]  = fe_q;
          rbyte[uart_frame_pkg::A_PE]  = pe_q;
          rbyte[uart_frame_pkg::A_DBL] = fmt_q.double_rate;
        end
        uart_frame_pkg::OFF_CTRL_B: begin
          rbyte[uart_frame_pkg::B_DIR]  = fmt_q.master;
          rbyte[uart_frame_pkg::B_RXEN] = rxen_q;
          rbyte[uart_frame_pkg::B_TXEN] = txen_q;
          rbyte[uart_frame_pkg::B_CSZ2] = fmt_q.char_size[2];
          rbyte[uart_frame_pkg::B_RX9]  = rx_data_q[8];
          rbyte[uart_frame_pkg::B_TX9]  = tx9_q;
        end
        uart_frame_pkg::OFF_BAUD_LOW: rbyte = div_q[7:0];
        uart_frame_pkg::OFF_SHARED: begin
          rbyte[uart_frame_pkg::C_SEL]       = 1'b1;
          rbyte[uart_frame_pkg::C_SYNC]      = fmt_q.sync;
          rbyte[uart_frame_pkg::C_PAR +: 2]  = fmt_q.parity_mode;
          rbyte[uart_frame_pkg::C_STOP]      = fmt_q.stop2;
          rbyte[uart_frame_pkg::C_CSZ +: 2]  = fmt_q.char_size[1:0];
          rbyte[uart_frame_pkg::C_POL]       = fmt_q.polarity;
        end
        default: rresp_d = uart_frame_pkg::RESP_SLVERR;
      endcase
      rdata_d = {24'h000000, rbyte};
    end
    if (rvalid_q && rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
    // hardware set wins over software clear
    if (tx_done) begin
      txc_d = 1'b1;
    end
    if (rx_done) begin
      rxc_d = 1'b1;
    end
    awready_d = !aw_held_d && !bvalid_d;
    wready_d  = !w_held_d && !bvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 5'h00;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= uart_frame_pkg::RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= uart_frame_pkg::RESP_OKAY;
      rdata_q   <= 32'h00000000;
      fmt_q     <= '{char_size: uart_frame_pkg::RST_CSZ, default: 1'b0};
      txen_q    <= 1'b0;
      rxen_q    <= 1'b0;
      tx9_q     <= 1'b0;
      div_q     <= uart_frame_pkg::RST_DIV;
      txc_q     <= 1'b0;
      rxc_q     <= 1'b0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q  <= w_held_d;
      awaddr_q  <= awaddr_d;
      wbyte_q   <= wbyte_d;
      wlane_q   <= wlane_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      fmt_q     <= fmt_d;
      txen_q    <= txen_d;
      rxen_q    <= rxen_d;
      tx9_q     <= tx9_d;
      div_q     <= div_d;
      txc_q     <= txc_d;
      rxc_q     <= rxc_d;
    end
  end

  // ----------------------------------------------------------------
  // baud tick, transfer clock and bit enables
  // ----------------------------------------------------------------
  baud_down_counter u_baud (
    .aclk    (aclk),
    .aresetn (aresetn),
    .divisor (div_q),
    .reload  (reload),
    .tick    (tick)
  );

  always_comb begin
    master   = fmt_q.sync && fmt_q.master;
    ovs_last = fmt_q.double_rate ? uart_frame_pkg::OVS_LAST_DBL
                                 : uart_frame_pkg::OVS_LAST_NORM;
    mid      = fmt_q.double_rate ? uart_frame_pkg::MID_DBL : uart_frame_pkg::MID_NORM;
    if (master) begin
      rise = tick && !xck_q;
      fall = tick && xck_q;
    end else begin
      rise = xck_s2_q && !xck_s3_q;
      fall = !xck_s2_q && xck_s3_q;
    end
    chg_edge   = fmt_q.sync && (fmt_q.polarity ? fall : rise);
    smp_edge   = fmt_q.sync && (fmt_q.polarity ? rise : fall);
    xck_d      = master ? (xck_q ^ tick) : 1'b0;
    xck_oe_n_d = !master;
    tx_ph_d    = tx_ph_q;
    if (tick) begin
      tx_ph_d = (tx_ph_q >= ovs_last) ? 4'h0 : tx_ph_q + 4'h1;
    end
    tx_bit_en = fmt_q.sync ? chg_edge : (tick && tx_ph_q >= ovs_last);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
      xck_s1_q <= 1'b0;
      xck_s2_q <= 1'b0;
      xck_s3_q <= 1'b0;
      xck_q    <= 1'b0;
      xck_oe_n <= 1'b1;
      tx_ph_q  <= 4'h0;
    end else begin
      rxd_s1_q <= rxd;
      rxd_s2_q <= rxd_s1_q;
      xck_s1_q <= xck_in;
      xck_s2_q <= xck_s1_q;
      xck_s3_q <= xck_s2_q;
      xck_q    <= xck_d;
      xck_oe_n <= xck_oe_n_d;
      tx_ph_q  <= tx_ph_d;
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  always_comb begin
    tx_word = {tx9_q, wbyte_q};
    frame   = 13'h1fff;
    frame[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (mask[i]) begin
        frame[i + 1] = tx_word[i];
      end
    end
    if (par_en) begin
      frame[n_bits + 4'h1] = ^(tx_word & mask) ^ par_odd;
    end
    total    = n_bits + 4'(par_en) + 4'(fmt_q.stop2) + 4'h2;
    tx_st_d  = tx_st_q;
    frame_d  = frame_q;
    tx_cnt_d = tx_cnt_q;
    txd_d    = txd_q;
    tx_done  = 1'b0;
    case (tx_st_q)
      uart_frame_pkg::TX_IDLE: begin
        if (tx_start) begin
          frame_d  = frame;
          tx_cnt_d = total;
          tx_st_d  = uart_frame_pkg::TX_BUSY;
        end
      end
      uart_frame_pkg::TX_BUSY: begin
        if (tx_bit_en && tx_cnt_q != 4'h0) begin
          txd_d    = frame_q[0];
          frame_d  = {1'b1, frame_q[12:1]};
          tx_cnt_d = tx_cnt_q - 4'h1;
        end else if (tx_bit_en) begin
          tx_st_d = uart_frame_pkg::TX_IDLE;
          tx_done = 1'b1;
        end
      end
      default: tx_st_d = uart_frame_pkg::TX_IDLE;
    endcase
    if (!txen_q) begin
      tx_st_d = uart_frame_pkg::TX_IDLE;
      txd_d   = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_q  <= uart_frame_pkg::TX_IDLE;
      frame_q  <= 13'h1fff;
      tx_cnt_q <= 4'h0;
      txd_q    <= 1'b1;
    end else begin
      tx_st_q  <= tx_st_d;
      frame_q  <= frame_d;
      tx_cnt_q <= tx_cnt_d;
      txd_q    <= txd_d;
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  always_comb begin
    rx_st_d   = rx_st_q;
    rx_ph_d   = rx_ph_q;
    rx_idx_d  = rx_idx_q;
    rx_sh_d   = rx_sh_q;
    rx_par_d  = rx_par_q;
    rx_data_d = rx_data_q;
    fe_d      = fe_q;
    pe_d      = pe_q;
    rx_done   = 1'b0;
    samp      = fmt_q.sync ? smp_edge : (tick && rx_ph_q == mid);
    if (tick) begin
      rx_ph_d = (rx_ph_q >= ovs_last) ? 4'h0 : rx_ph_q + 4'h1;
    end
    case (rx_st_q)
      uart_frame_pkg::RX_IDLE: begin
        if (!rxd_s2_q && fmt_q.sync && smp_edge) begin
          rx_st_d  = uart_frame_pkg::RX_BUSY;
          rx_idx_d = 4'h1;
          rx_sh_d  = 9'h000;
        end else if (!rxd_s2_q && !fmt_q.sync && tick) begin
          rx_st_d  = uart_frame_pkg::RX_BUSY;
          rx_ph_d  = 4'h1;
          rx_idx_d = 4'h0;
          rx_sh_d  = 9'h000;
        end
      end
      uart_frame_pkg::RX_BUSY: begin
        if (samp && rx_idx_q == 4'h0) begin
          rx_idx_d = 4'h1;
          if (rxd_s2_q) begin
            rx_st_d = uart_frame_pkg::RX_IDLE;
          end
        end else if (samp && rx_idx_q <= n_bits) begin
          rx_sh_d[rx_idx_q - 4'h1] = rxd_s2_q;
          rx_idx_d = rx_idx_q + 4'h1;
        end else if (samp && par_en && rx_idx_q == n_bits + 4'h1) begin
          rx_par_d = rxd_s2_q;
          rx_idx_d = rx_idx_q + 4'h1;
        end else if (samp) begin
          rx_data_d = rx_sh_q;
          fe_d      = !rxd_s2_q;
          pe_d      = par_en && ((^rx_sh_q) ^ par_odd ^ rx_par_q);
          rx_done   = 1'b1;
          rx_st_d   = uart_frame_pkg::RX_IDLE;
        end
      end
      default: rx_st_d = uart_frame_pkg::RX_IDLE;
    endcase
    if (!rxen_q) begin
      rx_st_d = uart_frame_pkg::RX_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_q   <= uart_frame_pkg::RX_IDLE;
      rx_ph_q   <= 4'h0;
      rx_idx_q  <= 4'h0;
      rx_sh_q   <= 9'h000;
      rx_par_q  <= 1'b0;
      rx_data_q <= 9'h000;
      fe_q      <= 1'b0;
      pe_q      <= 1'b0;
    end else begin
      rx_st_q   <= rx_st_d;
      rx_ph_q   <= rx_ph_d;
      rx_idx_q  <= rx_idx_d;
      rx_sh_q   <= rx_sh_d;
      rx_par_q  <= rx_par_d;
      rx_data_q <= rx_data_d;
      fe_q      <= fe_d;
      pe_q      <= pe_d;
    end
  end

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;
  assign txd     = txd_q;
  assign xck_out = xck_q;

endmodule

// [core/uart_frame_pkg.sv]
// package: offsets, field positions, reset values and types of the serial block
package uart_frame_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned   ADDR_W        = 5;
  localparam logic [4:0]    OFF_DATA      = 5'h00;
  localparam logic [4:0]    OFF_CTRL_A    = 5'h04;
  localparam logic [4:0]    OFF_CTRL_B    = 5'h08;
  localparam logic [4:0]    OFF_BAUD_LOW  = 5'h0c;
  localparam logic [4:0]    OFF_SHARED    = 5'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned   A_RXC         = 7;
  localparam int unsigned   A_TXC         = 6;
  localparam int unsigned   A_FE          = 4;
  localparam int unsigned   A_PE          = 2;
  localparam int unsigned   A_DBL         = 1;
  localparam int unsigned   B_DIR         = 5;
  localparam int unsigned   B_RXEN        = 4;
  localparam int unsigned   B_TXEN        = 3;
  localparam int unsigned   B_CSZ2        = 2;
  localparam int unsigned   B_RX9         = 1;
  localparam int unsigned   B_TX9         = 0;
  localparam int unsigned   C_SEL         = 7;
  localparam int unsigned   C_SYNC        = 6;
  localparam int unsigned   C_PAR         = 4;
  localparam int unsigned   C_STOP        = 3;
  localparam int unsigned   C_CSZ         = 1;
  localparam int unsigned   C_POL         = 0;
  localparam int unsigned   DIV_W         = 12;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [2:0]    RST_CSZ       = 3'h3;
  localparam logic [11:0]   RST_DIV       = 12'h000;
  localparam logic [3:0]    OVS_LAST_NORM = 4'hf;
  localparam logic [3:0]    OVS_LAST_DBL  = 4'h7;
  localparam logic [3:0]    MID_NORM      = 4'h8;
  localparam logic [3:0]    MID_DBL       = 4'h4;
  localparam logic [1:0]    RESP_OKAY     = 2'h0;
  localparam logic [1:0]    RESP_SLVERR   = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       sync;
    logic       master;
    logic       polarity;
    logic [1:0] parity_mode;
    logic       stop2;
    logic [2:0] char_size;
    logic       double_rate;
  } fmt_t;

  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_BUSY = 2'b10} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_BUSY = 2'b10} rx_state_t;

endpackage

// [core/baud_down_counter.sv]
// module: programmable baud down-counter giving a one-cycle tick
`timescale 1ns/1ps
module baud_down_counter (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] divisor,
  input  wire logic        reload,
  output logic             tick
);

  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic        tick_q;
  logic        tick_d;

  // ----------------------------------------------------------------
  // count down, reload at zero or on low byte write
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d  = cnt_q - 12'h001;
    tick_d = 1'b0;
    if (reload) begin
      cnt_d = divisor;
    end else if (cnt_q == 12'h000) begin
      cnt_d  = divisor;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= uart_frame_pkg::RST_DIV;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

// [tb/uart_peer.sv]
// remote serial peer driving the receive line
`timescale 1ns/1ps
module uart_peer (
  input  wire logic aclk,
  output logic      rxd,
  output logic      xck_in
);
  initial begin
    rxd = 1'b1;
    xck_in = 1'b0;
  end
  task automatic send(input logic [12:0] f, input int n, input int per);
    for (int b = 0; b < n; b++) begin
      rxd <= f[b];
      repeat (per) @(posedge aclk);
    end
    rxd <= 1'b1;
  endtask
endmodule

// [tb/uart_baud_clock_frame_properties.sv]
// checker: port properties of the serial block
`timescale 1ns/1ps
module uart_frame_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [4:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        txd
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_start_low: assert property ($fell(txd) |=> !txd)
    else $error("bit too short");
  a_idle_high: assert property ($rose(aresetn) |-> txd [*8])
    else $error("line not idle");
  a_shared_sel: assert property (
    arvalid && arready && araddr == uart_frame_pkg::OFF_SHARED |=> rvalid && rdata[7])
    else $error("shared read");
  a_read_turn: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer");
  a_write_turn: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write answer");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("b dropped");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("r dropped");
  a_byte_wide: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("rdata high");
  cover property ($fell(txd));
  cover property (bvalid && bresp == uart_frame_pkg::RESP_SLVERR);
  cover property (rvalid && rdata[4]);
endmodule
bind uart_baud_clock_frame uart_frame_checker chk_i (.aclk, .aresetn, .araddr, .arvalid,
  .arready, .rvalid, .rready, .rdata, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .bresp, .txd);

// [tb/uart_baud_clock_frame_tb_top.sv]
// testbench: registers, transmit capture and receive through the peer
`timescale 1ns/1ps
module uart_baud_clock_frame_tb_top;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, s2, dbl;
  logic arvalid, arready, rvalid, rready, rxd, txd, xck_in, xck_out, xck_oe_n;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, p;
  logic [7:0] q;
  logic [8:0] d, dm;
  logic [2:0] c;
  logic [12:0] fr, got;
  int seed, error_cnt, total_checks, fn, per, dv, i, j, t;
  uart_baud_clock_frame uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .rxd, .txd, .xck_in, .xck_out, .xck_oe_n);
  uart_peer peer (.aclk, .rxd, .xck_in);
  always #25 aclk = ~aclk;
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [12:0] g, input logic [12:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
    logic pa, pw, pb;
    @(posedge aclk);
    pa = 1'b1;
    pw = w;
    pb = 1'b1;
    {awaddr, araddr, wdata} <= {a, a, 24'h0, v};
    {awvalid, wvalid, arvalid, bready, rready} <= {w, w, !w, w, !w};
    for (int n = 0; n < 99 && pb; n++) begin
      @(posedge aclk);
      if (pa && (w ? awready : arready)) begin
        pa = 1'b0;
        {awvalid, arvalid} <= 2'b00;
      end
      if (pw && wready) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
      if (pb && !pa && !pw && (w ? bvalid : rvalid)) begin
        pb = 1'b0;
        {bready, rready} <= 2'b00;
        q = rdata[7:0];
        r = w ? bresp : rresp;
      end
    end
    if (pb) begin
      error_cnt++;
      close_out();
    end
  endtask
  task automatic mk(input logic [8:0] v);
    int k;
    k = c < 3'h4 ? c + 5 : (c == 3'h7 ? 9 : 8);
    dm = v & ((9'h1 << k) - 9'h1);
    fr = 13'h1ffe;
    for (j = 0; j < k; j++) fr[j + 1] = dm[j];
    if (p[1]) fr[k + 1] = ^dm ^ p[0];
    fn = k + 2 + p[1] + s2;
  endtask
  initial begin
    {aclk, aresetn, awvalid, wvalid, arvalid, bready, rready} = 7'h0;
    {awaddr, araddr, wdata, wstrb} = {10'h0, 32'h0, 4'hf};
    {seed, error_cnt, total_checks} = {32'he1fe, 64'h0};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    bus(1'b0, uart_frame_pkg::OFF_SHARED, 8'h0);
    chk(q, 8'h86);
    chk(xck_oe_n, 1'b1);
    bus(1'b1, uart_frame_pkg::OFF_SHARED, 8'h00);
    bus(1'b0, uart_frame_pkg::OFF_SHARED, 8'h0);
    chk(q, 8'h86);
    bus(1'b0, 5'h14, 8'h0);
    chk(r, uart_frame_pkg::RESP_SLVERR);
    for (i = 0; i < 6; i++) begin
      c = 3'($random(seed));
      if (c inside {[3'h4:3'h6]}) c = 3'h7;
      p = 2'($random(seed));
      if (p == 2'h1) p = 2'h0;
      s2 = (i == 4) | 1'($random(seed));
      dbl = 1'($random(seed));
      dv = $random(seed) & 3;
      d = 9'($random(seed));
      per = (dbl ? 8 : 16) * (dv + 1);
      bus(1'b1, uart_frame_pkg::OFF_CTRL_A, {2'h1, 4'h0, dbl, 1'b0});
      bus(1'b1, uart_frame_pkg::OFF_BAUD_LOW, 8'(dv));
      bus(1'b1, uart_frame_pkg::OFF_SHARED, {2'h2, p, s2, c[1:0], 1'b0});
      bus(1'b1, uart_frame_pkg::OFF_CTRL_B, {3'h0, 2'h3, c[2], 1'b0, d[8]});
      mk(d);
      bus(1'b1, uart_frame_pkg::OFF_DATA, d[7:0]);
      got = 13'h1fff;
      for (t = 0; t < 9999 && txd !== 1'b0; t++) #50;
      if (t == 9999) begin
        error_cnt++;
        close_out();
      end
      #((per / 2) * 50);
      for (j = 0; j < fn; j++) begin
        got[j] = txd;
        #(per * 50);
      end
      chk(got, fr);
      mk(9'($random(seed)));
      if (i == 4) fr[fn - 1] = 1'b0;
      if (i == 5) fr[fn - 1 - s2] = 1'b0;
      @(posedge aclk);
      peer.send(fr, fn, per);
      bus(1'b0, uart_frame_pkg::OFF_CTRL_A, 8'h0);
      chk(q[4], i == 5);
      chk(q[2], 1'b0);
      chk(q[6], 1'b1);
      bus(1'b0, uart_frame_pkg::OFF_CTRL_B, 8'h0);
      chk(q[1], dm[8]);
      bus(1'b0, uart_frame_pkg::OFF_DATA, 8'h0);
      chk(q, dm[7:0]);
      // low second stop bit looks like a start; let that frame run out
      if (i == 4) repeat (fn * per) @(posedge aclk);
      $display("test %0d done", i);
    end
    // synchronous master: pin driven, clock toggles once per tick
    bus(1'b1, uart_frame_pkg::OFF_CTRL_A, 8'h00);
    bus(1'b1, uart_frame_pkg::OFF_CTRL_B, 8'h38);
    bus(1'b1, uart_frame_pkg::OFF_SHARED, 8'hc6);
    repeat (2) @(posedge aclk);
    chk(xck_oe_n, 1'b0);
    dbl = xck_out;
    repeat (dv + 1) @(posedge aclk);
    chk(xck_out, !dbl);
    $display("test sync done");
    close_out();
  end
endmodule
